// ===== apdb_defines.vh
// register offsets, field positions, reset values and timing counts for the converter control block
`ifndef APDB_DEFINES_VH
`define APDB_DEFINES_VH
`define APDB_OFS_AD_LO      4'h4
`define APDB_OFS_AD_HI      4'h5
`define APDB_OFS_DA0_LO     4'h4
`define APDB_OFS_DA0_HI     4'h5
`define APDB_OFS_DA1_LO     4'h6
`define APDB_OFS_DA1_HI     4'h7
`define APDB_OFS_DI_LO      4'h6
`define APDB_OFS_DI_HI      4'h7
`define APDB_OFS_GAIN       4'h9
`define APDB_OFS_MUX        4'hA
`define APDB_OFS_MODE       4'hB
`define APDB_OFS_TRIG       4'hC
`define APDB_OFS_DO_LO      4'hD
`define APDB_OFS_DO_HI      4'hE
`define APDB_MODE_SW_POLL   3'h1
`define APDB_MODE_SW_ALT    3'h0
`define APDB_MODE_RST       3'h0
`define APDB_READY_BIT      4
`define APDB_CONV_TIME_NS   8000
`define APDB_CLK_PERIOD_NS  50
`define APDB_CONV_CYCLES    ((`APDB_CONV_TIME_NS + `APDB_CLK_PERIOD_NS - 1) / `APDB_CLK_PERIOD_NS)
`endif

// ===== apdb_dac_channel.v
// one double-buffered 12-bit output channel
`timescale 1ns/1ps
`default_nettype none
module apdb_dac_channel (
   input  wire        core_clk,   // system clock
   input  wire        sys_rst,    // synchronous reset, active high
   input  wire        wr_lo,      // low byte write strobe
   input  wire        wr_hi,      // high byte write strobe
   input  wire [7:0]  wdata,      // write data
   output reg  [11:0] dac_code    // code driving the converter
);
   reg [7:0] held_lo;

   always @(posedge core_clk) begin
      if (sys_rst) begin
         held_lo  <= 8'h00;
         dac_code <= 12'h000;
      end else begin
         if (wr_lo) begin
            held_lo <= wdata;
         end
         if (wr_hi) begin
            dac_code <= {wdata[3:0], held_lo};
         end
      end
   end
endmodule // apdb_dac_channel
`default_nettype wire

// ===== apdb_ctrl.v
// host i/o register decode, polled a/d sequencing and d/a loading
`timescale 1ns/1ps
`default_nettype none
`include "apdb_defines.vh"
module apdb_ctrl #(
   parameter CONV_CYCLES = `APDB_CONV_CYCLES
) (
   input  wire        core_clk,    // system clock, 20 MHz
   input  wire        sys_rst,     // synchronous reset, active high
   input  wire [3:0]  io_addr,     // offset above board base
   input  wire        io_wr,       // one-cycle write strobe
   input  wire        io_rd,       // read strobe
   input  wire [7:0]  io_wdata,    // write data
   output reg  [7:0]  io_rdata,    // read data
   output wire        adc_start,   // one-cycle trigger to the converter
   input  wire        adc_done,    // converter finished, one-cycle pulse
   input  wire [11:0] adc_data,    // converter result, offset binary
   output reg  [2:0]  adc_channel, // multiplexer select
   output reg  [7:0]  adc_gain,    // amplifier gain code
   output reg  [2:0]  adc_mode,    // trigger and transfer mode
   output wire        adc_irq_en,  // interrupt request enable, never set here
   output wire        adc_dma_en,  // dma request enable, never set here
   output wire [11:0] dac0_code,   // output channel 0 code
   output wire [11:0] dac1_code,   // output channel 1 code
   input  wire [15:0] din,         // digital inputs
   output reg  [15:0] dout         // digital outputs
);
   ////////////////////////////////////////////////////////////////////////////
   // one-hot sequencer states
   localparam ST_IDLE = 2'b01;
   localparam ST_BUSY = 2'b10;

   // one address compare shared by every write strobe below
   function hit;
      input [3:0] a;
      input [3:0] ofs;
      hit = (a == ofs);
   endfunction

   reg [1:0]  state;
   reg [1:0]  next_state;
   reg [15:0] conv_cnt;
   reg [11:0] result;
   reg        ready;
   reg [7:0]  next_rdata;

   ////////////////////////////////////////////////////////////////////////////
   // write decode; offsets 4 and 5 reach the output latches only on writes,
   // reads there see the conversion result instead
   wire wr_mode   = io_wr & hit(io_addr, `APDB_OFS_MODE);
   wire wr_mux    = io_wr & hit(io_addr, `APDB_OFS_MUX);
   wire wr_gain   = io_wr & hit(io_addr, `APDB_OFS_GAIN);
   wire wr_trig   = io_wr & hit(io_addr, `APDB_OFS_TRIG);
   wire wr_do_lo  = io_wr & hit(io_addr, `APDB_OFS_DO_LO);
   wire wr_do_hi  = io_wr & hit(io_addr, `APDB_OFS_DO_HI);
   wire wr_da0_lo = io_wr & hit(io_addr, `APDB_OFS_DA0_LO);
   wire wr_da0_hi = io_wr & hit(io_addr, `APDB_OFS_DA0_HI);
   wire wr_da1_lo = io_wr & hit(io_addr, `APDB_OFS_DA1_LO);
   wire wr_da1_hi = io_wr & hit(io_addr, `APDB_OFS_DA1_HI);

   // mode 0 also takes software triggers; the pacer modes ignore trigger writes
   wire sw_mode   = (adc_mode == `APDB_MODE_SW_POLL) | (adc_mode == `APDB_MODE_SW_ALT);
   // a conversion ends in the one cycle in which busy hands back to idle
   wire conv_end  = (state == ST_BUSY) & (next_state == ST_IDLE);

   // trigger accepted on any data value, only in a software-trigger mode
   assign adc_start  = wr_trig & sw_mode & (state == ST_IDLE);
   assign adc_irq_en = 1'b0;
   assign adc_dma_en = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // control registers; the settling time after a channel or gain change is the host's to wait
   always @(posedge core_clk) begin
      if (sys_rst) begin
         adc_mode <= `APDB_MODE_RST;
      end else if (wr_mode) begin
         adc_mode <= io_wdata[2:0];
      end
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         adc_channel <= 3'h0;
      end else if (wr_mux) begin
         adc_channel <= io_wdata[2:0];
      end
   end

   always @(posedge core_clk) begin
      if (sys_rst) begin
         adc_gain <= 8'h00;
      end else if (wr_gain) begin
         adc_gain <= io_wdata;
      end
   end

   // the two output bytes load apart, so a half-written word shows on the pins at once
   always @(posedge core_clk) begin
      if (sys_rst) begin
         dout <= 16'h0000;
      end else begin
         if (wr_do_lo) begin
            dout[7:0] <= io_wdata;
         end
         if (wr_do_hi) begin
            dout[15:8] <= io_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // conversion sequencer; a timeout covers a converter that never answers
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (adc_start) begin
               next_state = ST_BUSY;
            end
         end
         ST_BUSY: begin
            if (adc_done || conv_cnt == 16'h0000) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // sequencer state
   always @(posedge core_clk) begin
      if (sys_rst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // busy-cycle budget, so a converter that never answers cannot hang the flag
   always @(posedge core_clk) begin
      if (sys_rst) begin
         conv_cnt <= 16'h0000;
      end else if (adc_start) begin
         conv_cnt <= CONV_CYCLES[15:0];
      end else if (state == ST_BUSY) begin
         conv_cnt <= conv_cnt - 16'h0001;
      end
   end

   // start and end never meet: a busy sequencer refuses triggers
   always @(posedge core_clk) begin
      if (sys_rst) begin
         ready <= 1'b0;
      end else if (adc_start) begin
         ready <= 1'b1;
      end else if (conv_end) begin
         ready <= 1'b0;
      end
   end

   // a timed-out conversion keeps whatever the converter shows then
   always @(posedge core_clk) begin
      if (sys_rst) begin
         result <= 12'h000;
      end else if (conv_end) begin
         result <= adc_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reads: result bytes share offsets with output latches by direction
   always @* begin
      next_rdata = 8'h00;
      case (io_addr)
         `APDB_OFS_AD_LO: begin
            next_rdata = result[7:0];
         end
         `APDB_OFS_AD_HI: begin
            next_rdata[3:0]             = result[11:8];
            next_rdata[`APDB_READY_BIT] = ready;
         end
         `APDB_OFS_DI_LO: begin
            next_rdata = din[7:0];
         end
         `APDB_OFS_DI_HI: begin
            next_rdata = din[15:8];
         end
         // unmapped offsets read back as zero
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   // read data is registered and holds until the next read strobe
   always @(posedge core_clk) begin
      if (sys_rst) begin
         io_rdata <= 8'h00;
      end else if (io_rd) begin
         io_rdata <= next_rdata;
      end
   end

   // channel 0 latches at offsets 4 and 5, channel 1 at 6 and 7; only the strobes differ
   apdb_dac_channel u_dac0 (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .wr_lo    (wr_da0_lo),
      .wr_hi    (wr_da0_hi),
      .wdata    (io_wdata),
      .dac_code (dac0_code)
   );

   apdb_dac_channel u_dac1 (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .wr_lo    (wr_da1_lo),
      .wr_hi    (wr_da1_hi),
      .wdata    (io_wdata),
      .dac_code (dac1_code)
   );
endmodule // apdb_ctrl
`default_nettype wire

// ===== apdb_ctrl_properties.sv
// concurrent checks on the converter control ports
`timescale 1ns/1ps
`default_nettype none
module apdb_ctrl_props (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic [3:0]  io_addr,
   input wire logic        io_wr,
   input wire logic        io_rd,
   input wire logic [7:0]  io_wdata,
   input wire logic [7:0]  io_rdata,
   input wire logic        adc_start,
   input wire logic        adc_done,
   input wire logic [11:0] adc_data,
   input wire logic        adc_irq_en,
   input wire logic        adc_dma_en,
   input wire logic [11:0] dac0_code,
   input wire logic [11:0] dac1_code
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   wire logic w4 = io_wr && io_addr == 4'h4;
   wire logic w5 = io_wr && io_addr == 4'h5;
   wire logic r5 = io_rd && io_addr == 4'h5;
   sequence lo_hi; w4 ##1 !w4 ##1 w5; endsequence
   sequence trig_poll; adc_start ##2 r5; endsequence
   sequence done_poll; adc_done ##1 r5; endsequence
   AST_NO_REQ: assert property (!adc_irq_en && !adc_dma_en) else $error("request enable set");
   AST_TRIG: assert property (adc_start |-> io_wr && io_addr == 4'hC) else $error("stray start");
   AST_HI_LOAD: assert property (w5 |=> dac0_code[11:8] == $past(io_wdata[3:0])) else $error("no load");
   AST_HOLD: assert property (!w5 |=> $stable(dac0_code)) else $error("code moved");
   AST_LO_HI: assert property (lo_hi |=> dac0_code == {$past(io_wdata[3:0]), $past(io_wdata, 3)})
      else $error("wrong code");
   AST_DAC1: assert property (io_wr && io_addr == 4'h7 |=> dac1_code[11:8] == $past(io_wdata[3:0]))
      else $error("no load on second channel");
   AST_READY_SET: assert property (trig_poll |=> io_rdata[4]) else $error("ready low while busy");
   AST_READY_CLR: assert property (done_poll |=> io_rdata == {4'h0, $past(adc_data[11:8], 2)})
      else $error("bad high byte");
endmodule // apdb_ctrl_props
`default_nettype wire

// ===== apdb_conv_model.sv
// converter model: ends each conversion a fixed count after its start
`timescale 1ns/1ps
`default_nettype none
module apdb_conv_model #(
   parameter logic [3:0] DELAY = 4'h5 // odd puts the end on a poll slot
) (
   input  wire logic        core_clk,  // clock
   input  wire logic        sys_rst,   // reset
   input  wire logic        adc_start, // trigger
   input  wire logic [11:0] value,     // next result
   output logic             adc_done,  // end pulse
   output logic [11:0]      adc_data   // result
);
   logic [3:0] cnt;
   always @(posedge core_clk) begin
      if (sys_rst)
         cnt <= 4'h0;
      else if (adc_start)
         cnt <= DELAY;
      else if (cnt != 4'h0)
         cnt <= cnt - 4'h1;
   end
   assign adc_done = cnt == 4'h1;
   // inverted outside the end pulse so a sample at the wrong time shows
   assign adc_data = adc_done ? value : ~value;
endmodule // apdb_conv_model
`default_nettype wire

// ===== apdb_ctrl_test.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module apdb_ctrl_test;
   logic        core_clk = 1'b0, sys_rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0;
   logic        adc_start, adc_done, adc_irq_en, adc_dma_en;
   logic [2:0]  adc_channel, adc_mode;
   logic [3:0]  io_addr = 4'h0;
   logic [7:0]  io_wdata = 8'h00, io_rdata, adc_gain, q, l, h;
   logic [11:0] value = 12'h000, dac0_code, dac1_code, adc_data, v;
   logic [15:0] din = 16'h0000, dout;
   integer      seed = 32'he257_5d8a, fails = 0, checks_done = 0, cyc = 0, starts = 0, i, n;
   always #25 core_clk = ~core_clk;
   apdb_ctrl #(.CONV_CYCLES(20)) DUT (.core_clk(core_clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr),
      .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .adc_start(adc_start), .adc_done(adc_done),
      .adc_data(adc_data), .adc_channel(adc_channel), .adc_gain(adc_gain), .adc_mode(adc_mode),
      .adc_irq_en(adc_irq_en), .adc_dma_en(adc_dma_en), .dac0_code(dac0_code), .dac1_code(dac1_code),
      .din(din), .dout(dout));
   apdb_conv_model u_conv (.core_clk(core_clk), .sys_rst(sys_rst), .adc_start(adc_start), .value(value),
      .adc_done(adc_done), .adc_data(adc_data));
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge core_clk);
      io_wr <= 1'b0;
      #1;
   endtask
   task rd(input logic [3:0] a);
      @(posedge core_clk);
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge core_clk);
      io_rd <= 1'b0;
      #1 q = io_rdata;
   endtask
   function logic [11:0] dac_exp(input logic [7:0] hi, input logic [7:0] lo);
      dac_exp = {hi[3:0], lo};
   endfunction
   task print_verdict;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // counts trigger pulses the design hands to the converter
   always @(posedge core_clk) begin
      if (adc_start === 1'b1)
         starts <= starts + 1;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fails = fails + 1;
         print_verdict;
      end
   end
   initial begin
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      v = 12'($random(seed));
      wr(4'hB, 8'h01);
      wr(4'hA, 8'(v[2:0]));
      wr(4'h9, v[11:4]);
      repeat (20) @(posedge core_clk);
      chk(16'(adc_mode), 16'h0001);
      chk(16'(adc_channel), 16'(v[2:0]));
      chk(16'(adc_gain), 16'(v[11:4]));
      for (i = 0; i < 6; i = i + 1) begin
         value <= (i == 0) ? 12'h7FF : (i == 1) ? 12'hFFF : (i == 2) ? 12'h800 : 12'($random(seed));
         wr(4'hC, 8'($random(seed)));
         rd(4'h5);
         chk(16'(q[4]), 16'h0001);
         n = 0;
         while (q[4] !== 1'b0 && n < 20) begin
            rd(4'h5);
            n = n + 1;
         end
         chk(16'(q), 16'(value[11:8]));
         rd(4'h4);
         chk(16'(q), 16'(value[7:0]));
      end
      chk(16'(starts), 16'h0006);
      wr(4'hB, 8'h06);
      wr(4'hC, 8'($random(seed)));
      rd(4'h5);
      chk(16'(q[4]), 16'h0000);
      chk(16'(starts), 16'h0006);
      wr(4'hB, 8'h00);
      wr(4'hC, 8'($random(seed)));
      wr(4'hC, 8'($random(seed)));
      chk(16'(starts), 16'h0007);
      repeat (8) @(posedge core_clk);
      rd(4'h5);
      chk(16'(q), 16'(value[11:8]));
      for (i = 0; i < 2; i = i + 1) begin
         {h, l} = 16'($random(seed));
         wr(4'(4 + 2 * i), l);
         wr(4'(5 + 2 * i), h);
         chk(16'(i ? dac1_code : dac0_code), 16'(dac_exp(h, l)));
         v = 12'($random(seed));
         wr(4'(5 + 2 * i), v[7:0]);
         chk(16'(i ? dac1_code : dac0_code), 16'(dac_exp(v[7:0], l)));
         wr(4'(4 + 2 * i), v[11:4]);
         chk(16'(i ? dac1_code : dac0_code), 16'(dac_exp(v[7:0], l)));
         wr(4'(5 + 2 * i), h);
         chk(16'(i ? dac1_code : dac0_code), 16'(dac_exp(h, v[11:4])));
      end
      rd(4'h4);
      chk(16'(q), 16'(value[7:0]));
      {h, l} = 16'($random(seed));
      wr(4'hD, l);
      wr(4'hE, h);
      chk(dout, {h, l});
      @(posedge core_clk);
      din <= 16'($random(seed));
      rd(4'h6);
      chk(16'(q), 16'(din[7:0]));
      rd(4'h7);
      chk(16'(q), 16'(din[15:8]));
      print_verdict;
   end
endmodule // apdb_ctrl_test
bind apdb_ctrl apdb_ctrl_props u_props (.core_clk(core_clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr),
   .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .adc_start(adc_start), .adc_done(adc_done),
   .adc_data(adc_data), .adc_irq_en(adc_irq_en), .adc_dma_en(adc_dma_en), .dac0_code(dac0_code),
   .dac1_code(dac1_code));
`default_nettype wire
